// >>> design/boot_param_loader.sv
// Boot parameter loader with Avalon-MM register slave
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
module boot_param_loader #(
   parameter int unsigned TICK_CYCLES = loader_pkg::DELAY_UNIT_CYCLES
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [1:0] variant_i,
   input wire logic flash_protected_i,
   input wire logic password_lsb_i,
   output logic [15:0] flash_addr_o,
   output logic flash_rd_o,
   input wire logic [7:0] flash_rdata_i,
   input wire logic flash_rvalid_i,
   output logic routine_call_o,
   output logic [15:0] routine_addr_o,
   input wire logic routine_done_i,
   input wire logic [7:0] working_reg_six_i,
   input wire logic [7:0] working_reg_seven_i,
   output logic done_o,
   output logic [7:0] count_o,
   output logic [7:0] diag_node_address_o,
   output logic jump_user_o,
   output logic [15:0] jump_addr_o,
   output logic stay_boot_o,
   input wire logic frame_valid_i,
   input wire logic [7:0] frame_nad_i,
   output logic frame_accept_o,
   output logic frame_ignore_o
);
   import loader_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Submodules
   param_if pif[2] ();
   tick_if tif ();
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_chk
         param_check u_chk (
            .p(pif[gi])
         );
      end
   endgenerate
   tick_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .t(tif)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // State
   state_t state_reg;
   state_t state_next;
   variant_t variant_reg;
   logic start_reg;
   logic [1:0] idx_reg;
   logic [7:0] byte_reg [4];
   logic use_inv_reg;
   logic force_def_reg;
   logic [7:0] units_reg;
   logic count_ok_reg;
   logic nad_ok_reg;
   logic jumped_reg;
   logic wait_reg;
   logic [31:0] rdata_reg;
   logic done_reg;
   logic [7:0] count_reg;
   logic [7:0] nad_reg;
   logic stay_reg;
   logic jump_reg;
   logic flash_rd_reg;
   logic call_reg;
   logic accept_reg;
   logic ignore_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Decoding
   wire bus_req;
   wire bus_take;
   wire wr_take;
   wire restart_wr;
   wire [15:0] area_base;
   wire [15:0] read_addr;
   wire count_ok;
   wire nad_ok;
   wire [7:0] count_final;
   wire [7:0] nad_final;
   wire read_last;
   wire [31:0] status_word;
   wire [31:0] rd_mux;
   wire nad_match;
   variant_t variant_now;

   assign bus_req = avs_read_i || avs_write_i;
   assign bus_take = bus_req && !wait_reg;
   assign wr_take = bus_take && avs_write_i;
   assign restart_wr = wr_take && (avs_address_i == REG_CTRL)
                       && avs_writedata_i[CTRL_RESTART_BIT];
   assign variant_now = variant_t'(variant_i);
   assign area_base = (variant_reg == VARIANT_SMALL) ? AREA_BASE_SMALL : AREA_BASE_LARGE;
   assign read_addr = area_base + COUNT_OFFSET + {14'h0000, idx_reg};
   assign read_last = (idx_reg == READ_LAST);

   assign pif[0].value = byte_reg[0];
   assign pif[0].inv = byte_reg[1];
   assign pif[0].use_inv = use_inv_reg;
   assign pif[0].is_count = 1'b1;
   assign pif[1].value = byte_reg[2];
   assign pif[1].inv = byte_reg[3];
   assign pif[1].use_inv = use_inv_reg;
   assign pif[1].is_count = 1'b0;
   assign count_ok = pif[0].ok && !force_def_reg;
   assign nad_ok = pif[1].ok && !force_def_reg;
   assign count_final = count_ok ? byte_reg[0] : COUNT_DEFAULT;
   assign nad_final = nad_ok ? byte_reg[2] : NAD_DEFAULT;

   assign tif.run = (state_reg == S_WAIT);

   assign status_word = {26'h0000000, (state_reg != S_DONE), stay_reg, jumped_reg,
                         nad_ok_reg, count_ok_reg, done_reg};
   assign rd_mux = (avs_address_i == REG_STATUS) ? status_word :
                   (avs_address_i == REG_PARAMS) ? {16'h0000, nad_reg, count_reg} :
                   (avs_address_i == REG_DELAY) ? {24'h000000, units_reg} :
                   32'h00000000;
   assign nad_match = (frame_nad_i == nad_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // Sequence
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (variant_reg == VARIANT_MID) begin
               state_next = S_EVAL;
            end else if (flash_protected_i) begin
               state_next = password_lsb_i ? S_CALL : S_EVAL;
            end else begin
               state_next = S_READ;
            end
         end
         S_READ: begin
            if (flash_rvalid_i && read_last) begin
               state_next = S_EVAL;
            end
         end
         S_CALL: begin
            if (routine_done_i) begin
               state_next = S_EVAL;
            end
         end
         // Valid count waits, else stay in boot
         S_EVAL: begin
            state_next = count_ok ? S_WAIT : S_DONE;
         end
         S_WAIT: begin
            if (units_reg == 8'h00) begin
               state_next = S_JUMP;
            end
         end
         S_JUMP: begin
            state_next = S_DONE;
         end
         S_DONE: begin
            state_next = S_DONE;
         end
      endcase
      if (start_reg) begin
         state_next = S_IDLE;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         state_reg <= S_IDLE;
         start_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         start_reg <= restart_wr;
      end
   end

   // Strap capture and parameter source
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         variant_reg <= VARIANT_LARGE;
         use_inv_reg <= 1'b1;
         force_def_reg <= 1'b0;
      end else if (start_reg) begin
         variant_reg <= variant_now;
      end else if (state_reg == S_IDLE) begin
         force_def_reg <= (variant_reg == VARIANT_MID) || (flash_protected_i && !password_lsb_i);
         // Routine values get range check only
         use_inv_reg <= !flash_protected_i;
      end
   end

   // Byte capture from flash or routine
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         idx_reg <= 2'h0;
         for (int i = 0; i < 4; i++) begin
            byte_reg[i] <= 8'h00;
         end
      end else if (state_reg == S_IDLE) begin
         idx_reg <= 2'h0;
      end else if (state_reg == S_READ && flash_rvalid_i) begin
         byte_reg[idx_reg] <= flash_rdata_i;
         idx_reg <= idx_reg + 2'h1;
      end else if (state_reg == S_CALL && routine_done_i) begin
         byte_reg[0] <= working_reg_six_i;
         byte_reg[2] <= working_reg_seven_i;
      end
   end

   // Flash read strobe held across all four reads until the last byte returns
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         flash_rd_reg <= 1'b0;
         call_reg <= 1'b0;
      end else begin
         flash_rd_reg <= (state_next == S_READ) && !(state_reg == S_READ && flash_rvalid_i
                         && read_last);
         call_reg <= (state_next == S_CALL);
      end
   end

   // Results and delay
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         done_reg <= 1'b0;
         count_reg <= COUNT_DEFAULT;
         nad_reg <= NAD_DEFAULT;
         count_ok_reg <= 1'b0;
         nad_ok_reg <= 1'b0;
         units_reg <= 8'h00;
         stay_reg <= 1'b0;
         jump_reg <= 1'b0;
         jumped_reg <= 1'b0;
      end else begin
         jump_reg <= (state_reg == S_JUMP);
         if (start_reg) begin
            done_reg <= 1'b0;
            stay_reg <= 1'b0;
            jumped_reg <= 1'b0;
         end else if (state_reg == S_EVAL) begin
            done_reg <= 1'b1;
            count_reg <= count_final;
            nad_reg <= nad_final;
            count_ok_reg <= count_ok;
            nad_ok_reg <= nad_ok;
            units_reg <= count_final - COUNT_MIN;
            stay_reg <= !count_ok;
         end else if (state_reg == S_WAIT && tif.tick && units_reg != 8'h00) begin
            units_reg <= units_reg - 8'h01;
         end else if (state_reg == S_JUMP) begin
            jumped_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Frame address filter
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         accept_reg <= 1'b0;
         ignore_reg <= 1'b0;
      end else begin
         accept_reg <= frame_valid_i && done_reg && nad_match;
         ignore_reg <= frame_valid_i && !(done_reg && nad_match);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
      end else begin
         wait_reg <= !(bus_req && wait_reg);
         if (bus_req && wait_reg && avs_read_i) begin
            rdata_reg <= rd_mux;
         end
      end
   end

   assign avs_readdata_o = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign flash_addr_o = read_addr;
   assign flash_rd_o = flash_rd_reg;
   assign routine_call_o = call_reg;
   assign routine_addr_o = area_base;
   assign done_o = done_reg;
   assign count_o = count_reg;
   assign diag_node_address_o = nad_reg;
   assign jump_user_o = jump_reg;
   assign jump_addr_o = USER_ENTRY_ADDR;
   assign stay_boot_o = stay_reg;
   assign frame_accept_o = accept_reg;
   assign frame_ignore_o = ignore_reg;
endmodule

// >>> design/loader_pkg.sv
// Constants and types of the boot parameter loader
package loader_pkg;
   localparam logic [15:0] AREA_BASE_LARGE = 16'h2ff7;
   localparam logic [15:0] AREA_BASE_SMALL = 16'h0ff7;
   localparam logic [15:0] COUNT_OFFSET = 16'h0005;
   localparam logic [15:0] USER_ENTRY_ADDR = 16'h0000;
   localparam logic [1:0] READ_LAST = 2'h3;
   localparam logic [7:0] COUNT_MIN = 8'h01;
   localparam logic [7:0] COUNT_MAX = 8'h0c;
   localparam logic [7:0] NAD_RESERVED = 8'h00;
   localparam logic [7:0] COUNT_DEFAULT = 8'hff;
   localparam logic [7:0] NAD_DEFAULT = 8'h7f;
   localparam logic [7:0] CHECK_ADD = 8'h01;
   localparam logic [7:0] CHECK_SUM = 8'h00;
   localparam int unsigned DELAY_UNIT_US = 5000;
   localparam int unsigned CLK_MHZ = 20;
   localparam int unsigned DELAY_UNIT_CYCLES = DELAY_UNIT_US * CLK_MHZ;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_PARAMS = 4'h8;
   localparam logic [3:0] REG_DELAY = 4'hc;
   localparam int CTRL_RESTART_BIT = 0;
   localparam int ST_DONE_BIT = 0;
   localparam int ST_COUNT_OK_BIT = 1;
   localparam int ST_NAD_OK_BIT = 2;
   localparam int ST_JUMP_BIT = 3;
   localparam int ST_STAY_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   localparam int PAR_NAD_LSB = 8;
   typedef enum logic [1:0] {VARIANT_LARGE, VARIANT_SMALL, VARIANT_MID, VARIANT_SPARE} variant_t;
   typedef enum {S_IDLE, S_READ, S_CALL, S_EVAL, S_WAIT, S_JUMP, S_DONE} state_t;
endpackage

// >>> design/loader_if.sv
// Carriers between the loader and its checker and tick divider
`timescale 1ns/10ps
interface param_if;
   logic [7:0] value;
   logic [7:0] inv;
   logic use_inv;
   logic is_count;
   logic ok;
   modport user_side(output value, inv, use_inv, is_count, input ok);
   modport chk_side(input value, inv, use_inv, is_count, output ok);
endinterface

interface tick_if;
   logic run;
   logic tick;
   modport user_side(output run, input tick);
   modport gen_side(input run, output tick);
endinterface

// >>> design/param_check.sv
// Complement and range check of one parameter byte
`timescale 1ns/10ps
module param_check (
   param_if.chk_side p
);
   import loader_pkg::*;
   wire [7:0] sum;
   wire inv_ok;
   wire range_ok;
   assign sum = p.value + p.inv + CHECK_ADD;
   assign inv_ok = !p.use_inv || (sum == CHECK_SUM);
   assign range_ok = p.is_count ? (p.value >= COUNT_MIN && p.value <= COUNT_MAX)
                                : (p.value != NAD_RESERVED);
   assign p.ok = inv_ok && range_ok;
endmodule

// >>> design/tick_gen.sv
// Divider giving a one-cycle pulse per delay unit
`timescale 1ns/10ps
module tick_gen #(
   parameter int unsigned TICK_CYCLES = 100000
) (
   input wire logic mclk_i,
   input wire logic rstn_i,
   tick_if.gen_side t
);
   logic [16:0] cnt_reg;
   logic tick_reg;
   wire at_end;
   assign at_end = (cnt_reg == 17'(TICK_CYCLES - 1));
   assign t.tick = tick_reg;
   always_ff @(posedge mclk_i) begin
      if (!rstn_i || !t.run) begin
         cnt_reg <= 17'h00000;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= at_end ? 17'h00000 : cnt_reg + 17'h00001;
         tick_reg <= at_end;
      end
   end
endmodule

// >>> test/boot_param_loader_props.sv
// Port checker for the boot parameter loader
`timescale 1ns/10ps
module boot_param_loader_props (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [1:0] variant_i,
   input wire logic flash_protected_i,
   input wire logic password_lsb_i,
   input wire logic [15:0] flash_addr_o,
   input wire logic flash_rd_o,
   input wire logic routine_call_o,
   input wire logic [15:0] routine_addr_o,
   input wire logic done_o,
   input wire logic [7:0] count_o,
   input wire logic [7:0] diag_node_address_o,
   input wire logic jump_user_o,
   input wire logic [15:0] jump_addr_o,
   input wire logic stay_boot_o,
   input wire logic frame_valid_i,
   input wire logic [7:0] frame_nad_i,
   input wire logic frame_accept_o,
   input wire logic frame_ignore_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////
   sequence s_fetch_end;
      $fell(flash_rd_o);
   endsequence
   sequence s_done_soon;
      ##[1:3] done_o;
   endsequence
   a_fetch_then_done: assert property (s_fetch_end |-> s_done_soon)
      else $error("no done after fetch");
   a_count_range: assert property (done_o |-> count_o inside {[8'h01:8'h0c], 8'hff})
      else $error("count out of range");
   a_nad_nonzero: assert property (done_o |-> diag_node_address_o != 8'h00)
      else $error("zero node address");
   a_stay_default: assert property (stay_boot_o |-> count_o == 8'hff && !jump_user_o)
      else $error("stay with bad count");
   a_mid_default: assert property (done_o && variant_i == 2'h2 |->
      count_o == 8'hff && diag_node_address_o == 8'h7f && stay_boot_o)
      else $error("mid part not default");
   a_lock_default: assert property (done_o && flash_protected_i && !password_lsb_i |->
      count_o == 8'hff && diag_node_address_o == 8'h7f)
      else $error("locked part not default");
   a_no_read_prot: assert property (flash_protected_i || variant_i == 2'h2 |-> !flash_rd_o)
      else $error("read of protected flash");
   a_area_addr: assert property (flash_rd_o |->
      (flash_addr_o | 16'h0003) == (variant_i == 2'h1 ? 16'h0fff : 16'h2fff))
      else $error("flash address off");
   a_call_addr: assert property (routine_call_o |-> flash_protected_i && password_lsb_i &&
      routine_addr_o == (variant_i == 2'h1 ? 16'h0ff7 : 16'h2ff7))
      else $error("bad routine call");
   a_jump_valid: assert property (jump_user_o |->
      jump_addr_o == 16'h0000 && done_o && count_o inside {[8'h01:8'h0c]})
      else $error("bad jump");
   a_frame_match: assert property (frame_valid_i && done_o &&
      frame_nad_i == diag_node_address_o |=> frame_accept_o && !frame_ignore_o)
      else $error("own frame not taken");
   a_frame_other: assert property (frame_valid_i && frame_nad_i != diag_node_address_o
      |=> frame_ignore_o && !frame_accept_o)
      else $error("foreign frame taken");
endmodule

bind boot_param_loader boot_param_loader_props boot_param_loader_props_i (.mclk_i, .rstn_i,
   .variant_i, .flash_protected_i, .password_lsb_i, .flash_addr_o, .flash_rd_o,
   .routine_call_o, .routine_addr_o, .done_o, .count_o, .diag_node_address_o, .jump_user_o,
   .jump_addr_o, .stay_boot_o, .frame_valid_i, .frame_nad_i, .frame_accept_o, .frame_ignore_o);

// >>> test/flash_model.sv
// Program flash and user routine seen from the loader
`timescale 1ns/10ps
module flash_model (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [1:0] lat_i,
   input wire logic [7:0] area_i [9],
   input wire logic [15:0] flash_addr_i,
   input wire logic flash_rd_i,
   output logic [7:0] flash_rdata_o = 8'h00,
   output logic flash_rvalid_o = 1'b0,
   input wire logic routine_call_i,
   output logic routine_done_o = 1'b0,
   output logic [7:0] six_o = 8'h00,
   output logic [7:0] seven_o = 8'h00
);
   logic [1:0] wait_reg = 2'h0;
   logic busy;
   logic fire;
   logic good;
   assign busy = flash_rd_i || routine_call_i;
   assign fire = busy && wait_reg >= lat_i && !flash_rvalid_o && !routine_done_o;
   assign good = area_i[0] == 8'h7e && area_i[2] == 8'h7f && area_i[4] == 8'h22;
   ////////////////////////////////////////////////////////////////
   always @(posedge mclk_i) begin
      flash_rvalid_o <= 1'b0;
      routine_done_o <= 1'b0;
      flash_rdata_o <= ~flash_rdata_o;
      six_o <= ~six_o;
      seven_o <= ~seven_o;
      wait_reg <= (!rstn_i || !busy || fire) ? 2'h0 : wait_reg + 2'h1;
      if (fire && flash_rd_i) begin
         flash_rvalid_o <= 1'b1;
         flash_rdata_o <= area_i[flash_addr_i[3:0] - 4'h7];
      end
      if (fire && routine_call_i) begin
         routine_done_o <= 1'b1;
         six_o <= good ? area_i[1] : ~six_o;
         seven_o <= good ? area_i[3] : ~seven_o;
      end
   end
endmodule

// >>> test/lin_boot_param_loader_tb.sv
// Self-checking bench for the boot parameter loader
`timescale 1ns/10ps
module lin_boot_param_loader_tb;
   import loader_pkg::*;
   localparam int unsigned T = 10;
   logic mclk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] avs_address_i = 4'h0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [1:0] variant_i = 2'h0;
   logic flash_protected_i = 1'b0;
   logic password_lsb_i = 1'b0;
   logic frame_valid_i = 1'b0;
   logic [7:0] frame_nad_i = 8'h00;
   logic [1:0] lat = 2'h0;
   logic [31:0] avs_readdata_o;
   logic [15:0] flash_addr_o, routine_addr_o, jump_addr_o;
   logic [7:0] flash_rdata_i, working_reg_six_i, working_reg_seven_i, count_o, diag_node_address_o;
   logic avs_waitrequest_o, flash_rd_o, flash_rvalid_i, routine_call_o, routine_done_i, done_o;
   logic jump_user_o, stay_boot_o, frame_accept_o, frame_ignore_o;
   logic [7:0] area [9] = '{default: 8'h00};
   logic [7:0] cnr [6] = '{8'h00, 8'h01, 8'h0c, 8'h0d, 8'hff, 8'h07};
   logic [31:0] seed = 32'h0f0d9e8a;
   int errors = 0;
   int checked = 0;
   ////////////////////////////////////////////////////////////////
   boot_param_loader #(.TICK_CYCLES(T)) boot_param_loader_i (.mclk_i, .rstn_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
      .variant_i, .flash_protected_i, .password_lsb_i, .flash_addr_o, .flash_rd_o,
      .flash_rdata_i, .flash_rvalid_i, .routine_call_o, .routine_addr_o, .routine_done_i,
      .working_reg_six_i, .working_reg_seven_i, .done_o, .count_o, .diag_node_address_o,
      .jump_user_o, .jump_addr_o, .stay_boot_o, .frame_valid_i, .frame_nad_i, .frame_accept_o,
      .frame_ignore_o);
   flash_model flash_model_i (.mclk_i, .rstn_i, .lat_i(lat), .area_i(area),
      .flash_addr_i(flash_addr_o), .flash_rd_i(flash_rd_o), .flash_rdata_o(flash_rdata_i),
      .flash_rvalid_o(flash_rvalid_i), .routine_call_i(routine_call_o),
      .routine_done_o(routine_done_i), .six_o(working_reg_six_i), .seven_o(working_reg_seven_i));
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [7:0] pick(input logic [7:0] v, input logic [7:0] inv,
      input logic cnt, input logic chk);
      logic ok;
      ok = (!chk || 8'(v + inv + 8'h01) == 8'h00) && (cnt ? v inside {[8'h01:8'h0c]} : v != 8'h00);
      return ok ? v : (cnt ? 8'hff : 8'h7f);
   endfunction
   task automatic results();
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0 && n < 20) begin
         @(posedge mclk_i);
         n++;
      end
      if (n == 20) chk({31'h0, avs_waitrequest_o}, 32'h0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic wait_done();
      int k;
      k = 0;
      while (done_o !== 1'b1 && k < 100) begin
         @(posedge mclk_i);
         k++;
      end
   endtask
   task automatic frame(input logic [7:0] a, input logic [1:0] e);
      frame_valid_i <= 1'b1;
      frame_nad_i <= a;
      @(posedge mclk_i);
      frame_valid_i <= 1'b0;
      @(posedge mclk_i);
      chk({30'h0, frame_accept_o, frame_ignore_o}, {30'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic run(input int i);
      logic [7:0] c, cn, n, nn, ec, en;
      logic [1:0] v;
      logic p, l, s;
      logic [31:0] r, q;
      int k;
      r = rnd();
      c = (i < 6) ? cnr[i] : {4'h0, r[3:0]};
      n = (i == 1) ? 8'h00 : r[15:8];
      v = (i < 4) ? {1'b0, r[22]} : r[23:22];
      p = r[24] && i > 3;
      l = r[25] && v != 2'h2;
      // inverse stored, broken now and then
      cn = ~c ^ {7'h0, r[17:16] == 2'h0 && i > 3};
      nn = ~n ^ {7'h0, r[19:18] == 2'h0 && i > 3};
      if (v == 2'h2 || (p && !l)) begin
         ec = 8'hff;
         en = 8'h7f;
      end else begin
         ec = pick(c, cn, 1'b1, !p);
         en = pick(n, nn, 1'b0, !p);
      end
      s = ec == 8'hff;
      rstn_i <= 1'b0;
      lat <= r[21:20];
      variant_i <= v;
      flash_protected_i <= p;
      password_lsb_i <= l;
      // routine bytes ahead of the values
      area <= '{8'h7e, c, 8'h7f, n, 8'h22, c, cn, n, nn};
      repeat (8) @(posedge mclk_i);
      rstn_i <= 1'b1;
      wait_done();
      chk({7'h0, done_o, diag_node_address_o, count_o}, {8'h01, en, ec});
      k = 0;
      while (jump_user_o !== 1'b1 && k < 200) begin
         @(posedge mclk_i);
         k++;
      end
      if (s) chk({k[7:0], 7'h0, stay_boot_o}, {8'hc8, 8'h01});
      else chk({31'h0, k >= (ec - 8'h01) * T && k <= (ec - 8'h01) * T + 5}, 32'h1);
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk(q & 32'h3b, {26'h0, 1'b0, s, !s, 1'b0, !s, 1'b1});
      bus(1'b1, REG_PARAMS, r, q);
      bus(1'b0, REG_PARAMS, 32'h0, q);
      chk(q, {16'h0, en, ec});
      bus(1'b0, REG_DELAY, 32'h0, q);
      chk(q, {24'h0, s ? ec - 8'h01 : 8'h00});
      bus(1'b0, 4'h2, 32'h0, q);
      chk(q, 32'h0);
      frame(en, 2'b10);
      frame(en ^ 8'h01, 2'b01);
      if (i == 2) begin
         bus(1'b1, REG_CTRL, 32'h1, q);
         @(posedge mclk_i);
         chk({31'h0, done_o}, 32'h0);
         wait_done();
         chk({7'h0, done_o, diag_node_address_o, count_o}, {8'h01, en, ec});
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      forever #25 mclk_i = ~mclk_i;
   end
   initial begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      results();
   end
   initial begin
      @(posedge mclk_i);
      for (int i = 0; i < 16; i++) begin
         run(i);
      end
      results();
   end
endmodule
